// File: logic/hpc_pkg.sv
// Shared constants and types for the host-port pin control block.
package hpc_pkg;

  // --------------------------------------------------------------------------
  // Register selection codes
  // --------------------------------------------------------------------------
  localparam logic [1:0] HPC_SEL_CONTROL = 2'h0;
  localparam logic [1:0] HPC_SEL_DATA_INC = 2'h1;
  localparam logic [1:0] HPC_SEL_ADDRESS = 2'h2;
  localparam logic [1:0] HPC_SEL_DATA = 2'h3;

  // --------------------------------------------------------------------------
  // Reset values and timing
  // --------------------------------------------------------------------------
  localparam logic [15:0] HPC_ADDR_RST = 16'h0000;
  localparam logic [7:0]  HPC_DATA_RST = 8'h00;
  localparam int          HPC_FIFO_DEPTH = 8;
  localparam int          HPC_SYNC_STAGES = 2;
  localparam logic [16:0] HPC_SYNC_RST = 17'h001FE;

  typedef enum logic [1:0] {
    HPC_IDLE   = 2'b00,
    HPC_ACCESS = 2'b01,
    HPC_WAIT   = 2'b10,
    HPC_DONE   = 2'b11
  } hpc_state_t;

endpackage

// File: logic/hpc_fifo.sv
// Small synchronous FIFO with valid/ready on both sides.
`timescale 1ns/100ps
module hpc_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("hpc_fifo depth must be a power of two");
  end

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0]      wr_q;
  logic [AW:0]      rd_q;
  logic             push;
  logic             pop;

  assign in_ready  = (wr_q - rd_q) != (AW+1)'(DEPTH);
  assign out_valid = wr_q != rd_q;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  assign out_data  = mem_q[rd_q[AW-1:0]];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule

// File: logic/hpc_pin_control.sv
// Pin-level control of the 8-bit parallel host port.
//
// Overview of operation
// - Host read/write strobes on the two data strobes time each transfer.
// - Address strobe latches the presented address into the host address register.
// - Read/write select level sets direction of each transfer.
// - Ready output tells host when the next transfer may proceed.
// - Ready and interrupt outputs float while the output-disable condition holds.
// - Interrupt output signals host and stays high throughout reset.
// - With port disabled the interrupt pin may carry the timer one output.
// - Module enable is sampled at reset release; high enables the port.
// - Low or open module enable during reset disables the port.
// - Once disabled, module enable changes are ignored until next reset.
// - Strobe and control pullups are on while module enable is low, and also during reset and the two clocks after release.
// - Two register-select inputs route the access to one of three registers.
// - Byte identifier marks first or second byte of a word transfer.
// - Output disable is active: test reset low, emulation zero high, one low.
`timescale 1ns/100ps
module hpc_pin_control
  import hpc_pkg::*;
#(
  parameter int FIFO_DEPTH = HPC_FIFO_DEPTH
) (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        host_data_strobe_a_n,
  input  wire logic        host_data_strobe_b_n,
  input  wire logic        host_address_strobe_n,
  input  wire logic        host_read_write_select,
  input  wire logic        host_chip_select_n,
  input  wire logic        register_select_low,
  input  wire logic        register_select_high,
  input  wire logic        byte_half_identifier,
  input  wire logic        host_port_module_enable,
  input  wire logic [7:0]  host_data_in,
  output logic [7:0]       host_data_out,
  output logic             host_data_oe,
  output logic             host_port_ready,
  output logic             host_port_ready_oe,
  output logic             host_interrupt_out,
  output logic             host_interrupt_oe,
  output logic             host_pullup_enable,
  input  wire logic        test_reset,
  input  wire logic        emulation_pin_zero,
  input  wire logic        emulation_one_or_disable,
  input  wire logic        timer_one_output,
  input  wire logic        timer_on_interrupt_pin,
  input  wire logic        host_interrupt_request,
  output logic [15:0]      host_address_register,
  output logic             port_enabled,
  output logic [17:0]      mem_req_data,
  output logic             mem_req_valid,
  input  wire logic        mem_req_ready,
  output logic             mem_req_write,
  input  wire logic [7:0]  mem_rd_data,
  input  wire logic        mem_rd_valid
);

  if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0) begin : g_bad_depth
    $error("hpc_pin_control needs a FIFO depth that is a power of two");
  end

  // --------------------------------------------------------------------------
  // Input synchronisers
  // --------------------------------------------------------------------------
  localparam int NS = 17;
  logic [NS-1:0] raw;
  logic [NS-1:0] s1_q;
  logic [NS-1:0] s2_q;

  assign raw = {host_data_in, byte_half_identifier, register_select_high,
                register_select_low, host_chip_select_n, host_read_write_select,
                host_address_strobe_n, host_data_strobe_b_n, host_data_strobe_a_n,
                host_port_module_enable};

  // The first stage feeds only the second; all logic reads s2_q.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= HPC_SYNC_RST;
      s2_q <= HPC_SYNC_RST;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
    end
  end

  logic       en_s;
  logic       strobe_s;
  logic       as_n_s;
  logic       rw_s;
  logic       cs_n_s;
  logic [1:0] sel_s;
  logic       bil_s;
  logic [7:0] din_s;

  assign en_s     = s2_q[0];
  assign strobe_s = !(s2_q[1] && s2_q[2]);
  assign as_n_s   = s2_q[3];
  assign rw_s     = s2_q[4];
  assign cs_n_s   = s2_q[5];
  assign sel_s    = s2_q[7:6];
  assign bil_s    = s2_q[8];
  assign din_s    = s2_q[16:9];

  // --------------------------------------------------------------------------
  // Module enable capture
  // --------------------------------------------------------------------------
  // The synchroniser shows its reset value for two clocks after release, so the
  // pin is caught only once it has passed both stages, then frozen.
  logic [1:0] settle_q;
  logic       captured_q;
  logic       enabled_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_q   <= 2'h0;
      captured_q <= 1'b0;
      enabled_q  <= 1'b0;
    end else if (!captured_q) begin
      if (settle_q == 2'(HPC_SYNC_STAGES)) begin
        captured_q <= 1'b1;
        enabled_q  <= en_s;
      end else begin
        settle_q <= settle_q + 2'h1;
      end
    end
  end

  // After capture, later changes of the pin reach only the pullups, not port_enabled.
  assign port_enabled = enabled_q;

  // Pullups on while the enable pin reads low.
  assign host_pullup_enable = !en_s;

  // --------------------------------------------------------------------------
  // Address latch
  // --------------------------------------------------------------------------
  logic as_n_d1_q;
  logic as_fall;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      as_n_d1_q <= 1'b1;
    end else begin
      as_n_d1_q <= as_n_s;
    end
  end

  assign as_fall = as_n_d1_q && !as_n_s && !cs_n_s && enabled_q;

  // --------------------------------------------------------------------------
  // Transfer sequencer
  // --------------------------------------------------------------------------
  hpc_state_t state_q;
  logic       strobe_d1_q;
  logic       start;
  logic       fifo_in_ready;
  logic [7:0] rd_data_q;
  logic       rd_oe_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      strobe_d1_q <= 1'b0;
    end else begin
      strobe_d1_q <= strobe_s;
    end
  end

  // Accesses without chip select are not recognised.
  assign start = strobe_s && !strobe_d1_q && !cs_n_s && enabled_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      host_address_register <= HPC_ADDR_RST;
    end else if (as_fall) begin
      host_address_register <= {host_address_register[7:0], din_s};
    end else if (start && sel_s == HPC_SEL_ADDRESS && !rw_s && fifo_in_ready) begin
      if (bil_s) begin
        host_address_register[7:0] <= din_s;
      end else begin
        host_address_register[15:8] <= din_s;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= HPC_IDLE;
    end else begin
      case (state_q)
        HPC_IDLE: begin
          if (start && fifo_in_ready) begin
            state_q <= (rw_s && sel_s != HPC_SEL_ADDRESS) ? HPC_WAIT : HPC_DONE;
          end
        end
        HPC_WAIT: begin
          if (mem_rd_valid) begin
            state_q <= HPC_DONE;
          end
        end
        HPC_DONE: begin
          if (!strobe_s) begin
            state_q <= HPC_IDLE;
          end
        end
        default: state_q <= HPC_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data_q <= HPC_DATA_RST;
      rd_oe_q   <= 1'b0;
    end else begin
      if (state_q == HPC_WAIT && mem_rd_valid) begin
        rd_data_q <= mem_rd_data;
      end else if (start && rw_s && sel_s == HPC_SEL_ADDRESS) begin
        rd_data_q <= bil_s ? host_address_register[7:0] : host_address_register[15:8];
      end
      rd_oe_q <= strobe_s && rw_s && !cs_n_s && enabled_q;
    end
  end

  logic off_active;
  assign off_active = !test_reset && emulation_pin_zero && !emulation_one_or_disable;

  assign host_data_out = rd_data_q;
  assign host_data_oe  = rd_oe_q && !off_active;

  // Request word: select, byte identifier, read flag, data byte, then zero padding.
  logic [17:0] req_word;
  assign req_word = {sel_s, bil_s, rw_s, din_s, 6'h00};

  hpc_fifo #(.WIDTH(18), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_data   (req_word),
    .in_valid  (start && state_q == HPC_IDLE && sel_s != HPC_SEL_ADDRESS),
    .in_ready  (fifo_in_ready),
    .out_data  (mem_req_data),
    .out_valid (mem_req_valid),
    .out_ready (mem_req_ready)
  );

  assign mem_req_write = !mem_req_data[14];

  // --------------------------------------------------------------------------
  // Output pins
  // --------------------------------------------------------------------------

  // Not ready while a read waits on memory or the FIFO is full.
  assign host_port_ready    = state_q != HPC_WAIT && fifo_in_ready;
  assign host_port_ready_oe = !off_active;
  assign host_interrupt_oe  = !off_active;

  always_comb begin
    if (!rst_n) begin
      host_interrupt_out = 1'b1;
    end else if (!enabled_q && timer_on_interrupt_pin) begin
      host_interrupt_out = timer_one_output;
    end else begin
      host_interrupt_out = !host_interrupt_request;
    end
  end

  // --------------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------------
  rdy_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == HPC_WAIT |-> !host_port_ready) else $error("ready high during pending read");
  off_float_a: assert property (@(posedge clk) disable iff (!rst_n)
    off_active |-> !host_port_ready_oe && !host_interrupt_oe) else $error("drive while off");
  en_frozen_a: assert property (@(posedge clk) disable iff (!rst_n)
    captured_q && $past(captured_q) |-> $stable(enabled_q)) else $error("enable changed");
  cs_ignore_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == HPC_IDLE && cs_n_s |=> state_q == HPC_IDLE)
    else $error("transfer started without chip select");
  addr_latch_a: assert property (@(posedge clk) disable iff (!rst_n)
    as_fall |=> host_address_register[7:0] == $past(din_s)) else $error("address not latched");
  pullup_on_a: assert property (@(posedge clk) disable iff (!rst_n)
    captured_q |-> host_pullup_enable == !$past(host_port_module_enable, 2))
    else $error("pullup wrong");
  read_wait_a: assert property (@(posedge clk) disable iff (!rst_n)
    state_q == HPC_IDLE && start && fifo_in_ready && rw_s && sel_s != HPC_SEL_ADDRESS
    |=> state_q == HPC_WAIT) else $error("read did not wait");
  timer_pin_a: assert property (@(posedge clk) disable iff (!rst_n)
    !enabled_q && timer_on_interrupt_pin |-> host_interrupt_out == timer_one_output)
    else $error("timer not routed");
  dis_nostart_a: assert property (@(posedge clk) disable iff (!rst_n)
    !enabled_q |-> state_q == HPC_IDLE && !mem_req_valid) else $error("disabled port started");
  cov_read_c: cover property (@(posedge clk) state_q == HPC_WAIT ##[1:20] state_q == HPC_DONE);
  cov_write_c: cover property (@(posedge clk) start && !rw_s);
  cov_full_c: cover property (@(posedge clk) !fifo_in_ready);
endmodule

// File: verif/hpc_host_model.sv
// Behavioural host processor driving the parallel port pins.
`timescale 1ns/100ps
module hpc_host_model
  import hpc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       host_port_ready,
  input  wire logic [7:0] host_data_out,
  output logic            host_data_strobe_a_n,
  output logic            host_data_strobe_b_n,
  output logic            host_address_strobe_n,
  output logic            host_read_write_select,
  output logic            host_chip_select_n,
  output logic            register_select_low,
  output logic            register_select_high,
  output logic            byte_half_identifier,
  output logic [7:0]      host_data_in,
  output logic [7:0]      rd_data
);
  initial begin
    {host_data_strobe_a_n, host_data_strobe_b_n, host_address_strobe_n} = 3'h7;
    host_chip_select_n = 1'b1;
    {host_read_write_select, register_select_high, register_select_low} = 3'h0;
    byte_half_identifier = 1'b0;
    host_data_in = 8'h00;
    rd_data = 8'h00;
  end

  // The bus settles a cycle before the strobe falls; the strobe is held
  // until ready, but waits no more than 60 cycles, so a slower device is overrun.
  task automatic access(input logic r, input logic c, input logic [1:0] s,
                        input logic bl, input logic [7:0] d, input logic ub);
    int n;
    @(negedge clk);
    host_read_write_select = r;
    host_chip_select_n = c;
    {register_select_high, register_select_low} = s;
    byte_half_identifier = bl;
    host_data_in = d;
    @(negedge clk);
    if (ub) host_data_strobe_b_n = 1'b0;
    else host_data_strobe_a_n = 1'b0;
    repeat (4) @(negedge clk);
    n = 0;
    while (host_port_ready !== 1'b1 && n < 60) begin
      @(negedge clk);
      n++;
    end
    repeat (2) @(negedge clk);
    rd_data = host_data_out;
    {host_data_strobe_a_n, host_data_strobe_b_n, host_chip_select_n} = 3'h7;
    host_data_in = ~d;
    repeat (6) @(negedge clk);
  endtask

  task automatic addr_latch(input logic [7:0] d, input logic bl);
    @(negedge clk);
    {host_chip_select_n, byte_half_identifier, host_data_in} = {1'b0, bl, d};
    @(negedge clk);
    host_address_strobe_n = 1'b0;
    repeat (4) @(negedge clk);
    {host_address_strobe_n, host_chip_select_n} = 2'h3;
    host_data_in = ~d;
    repeat (4) @(negedge clk);
  endtask
endmodule

// File: verif/hpc_pin_control_tb.sv
// Self-checking bench for the host-port pin control block.
`timescale 1ns/100ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin \
  $display("CHECK FAILED %s exp %h got %h", n, e, g); n_fail++; end end
module hpc_pin_control_tb;
  import hpc_pkg::*;
  logic clk = 0, rst_n = 0, host_port_module_enable = 1, test_reset = 0;
  logic emulation_pin_zero = 0, emulation_one_or_disable = 0, timer_one_output = 0;
  logic timer_on_interrupt_pin = 0, host_interrupt_request = 0, mem_req_ready = 1;
  logic mem_rd_valid = 0, last_wr = 0;
  logic [7:0] mem_rd_data = 8'h00, mem_val = 8'h00, a, b;
  logic host_data_strobe_a_n, host_data_strobe_b_n, host_address_strobe_n;
  logic host_read_write_select, host_chip_select_n, register_select_low;
  logic register_select_high, byte_half_identifier, host_data_oe, host_port_ready;
  logic host_port_ready_oe, host_interrupt_out, host_interrupt_oe, host_pullup_enable;
  logic port_enabled, mem_req_valid, mem_req_write;
  logic [7:0] host_data_in, host_data_out;
  logic [15:0] host_address_register;
  logic [17:0] mem_req_data, last_req = 18'h00000;
  int n_fail = 0, num_checks = 0, req_cnt = 0, rd_seen = 0, rd_done = 0, c0;
  int oe_cnt = 0, oe_c = 0;

  hpc_pin_control #(.FIFO_DEPTH(HPC_FIFO_DEPTH)) i_dut (.clk, .rst_n,
    .host_data_strobe_a_n, .host_data_strobe_b_n, .host_address_strobe_n,
    .host_read_write_select, .host_chip_select_n, .register_select_low,
    .register_select_high, .byte_half_identifier, .host_port_module_enable,
    .host_data_in, .host_data_out, .host_data_oe, .host_port_ready,
    .host_port_ready_oe, .host_interrupt_out, .host_interrupt_oe, .host_pullup_enable,
    .test_reset, .emulation_pin_zero, .emulation_one_or_disable, .timer_one_output,
    .timer_on_interrupt_pin, .host_interrupt_request, .host_address_register,
    .port_enabled, .mem_req_data, .mem_req_valid, .mem_req_ready, .mem_req_write,
    .mem_rd_data, .mem_rd_valid);

  hpc_host_model i_host (.clk, .host_port_ready, .host_data_out, .host_data_strobe_a_n,
    .host_data_strobe_b_n, .host_address_strobe_n, .host_read_write_select,
    .host_chip_select_n, .register_select_low, .register_select_high,
    .byte_half_identifier, .host_data_in, .rd_data());

  always #4 clk = ~clk;

  // Counts cycles in which the port drives the data pins toward the host.
  always @(posedge clk) if (host_data_oe === 1'b1) oe_cnt <= oe_cnt + 1;

  always @(posedge clk) if (mem_req_valid && mem_req_ready) begin
    last_req <= mem_req_data;
    last_wr <= mem_req_write;
    req_cnt <= req_cnt + 1;
    if (!mem_req_write) rd_seen <= rd_seen + 1;
  end

  // Memory answers reads after a random delay, so the port must hold the host off.
  initial forever begin
    @(negedge clk);
    if (rd_seen != rd_done) begin
      repeat ($urandom_range(1, 6)) @(negedge clk);
      `CHK("ready_pending", 1'b0, host_port_ready)
      {mem_rd_valid, mem_rd_data} = {1'b1, mem_val};
      @(negedge clk);
      {mem_rd_valid, mem_rd_data} = {1'b0, ~mem_val};
      rd_done++;
    end
  end

  task automatic finish_test();
    if (n_fail == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic do_reset(input logic en);
    @(negedge clk);
    rst_n = 0;
    host_port_module_enable = en;
    repeat (5) @(negedge clk);
    `CHK("int_in_reset", 1'b1, host_interrupt_out)
    rst_n = 1;
    repeat (4) @(negedge clk);
  endtask

  task automatic wr(input logic [1:0] s);
    logic [7:0] d;
    logic bl;
    d = 8'($urandom);
    bl = 1'($urandom);
    c0 = req_cnt;
    oe_c = oe_cnt;
    i_host.access(1'b0, 1'b0, s, bl, d, 1'($urandom));
    `CHK("req_cnt", c0 + 1, req_cnt)
    `CHK("req_word", {s, bl, 1'b0, d, 6'h00}, last_req)
    `CHK("req_write", 1'b1, last_wr)
    `CHK("wr_oe", oe_c, oe_cnt)
  endtask

  initial begin
    #400000;
    n_fail++;
    finish_test();
  end

  initial begin
    void'($urandom(32'hA0CF9E8E));
    do_reset(1'b1);
    `CHK("enabled", 1'b1, port_enabled)
    for (int i = 0; i < 8; i++) begin
      @(negedge clk);
      {test_reset, emulation_pin_zero, emulation_one_or_disable} = 3'(i);
      #1;
      `CHK("ready_oe", 1'(i != 2), host_port_ready_oe)
      `CHK("int_oe", 1'(i != 2), host_interrupt_oe)
    end
    @(negedge clk);
    {test_reset, emulation_pin_zero, emulation_one_or_disable} = 3'h0;
    repeat (4) begin
      @(negedge clk);
      host_interrupt_request = 1'($urandom);
      @(negedge clk);
      `CHK("int_out", !host_interrupt_request, host_interrupt_out)
    end
    a = 8'($urandom);
    b = 8'($urandom);
    i_host.addr_latch(a, 1'b0);
    i_host.addr_latch(b, 1'b1);
    `CHK("addr", {a, b}, host_address_register)
    // Address register written and read back through the data strobes.
    i_host.access(1'b0, 1'b0, HPC_SEL_ADDRESS, 1'b0, b, 1'b1);
    i_host.access(1'b0, 1'b0, HPC_SEL_ADDRESS, 1'b1, a, 1'b0);
    `CHK("addr_wr", {b, a}, host_address_register)
    i_host.access(1'b1, 1'b0, HPC_SEL_ADDRESS, 1'b1, 8'h00, 1'b0);
    `CHK("addr_rd", a, i_host.rd_data)
    wr(HPC_SEL_CONTROL);
    wr(HPC_SEL_DATA_INC);
    wr(HPC_SEL_DATA);
    repeat (3) begin
      mem_val = 8'($urandom);
      oe_c = oe_cnt;
      i_host.access(1'b1, 1'b0, HPC_SEL_DATA, 1'b0, 8'h00, 1'b0);
      `CHK("rd_data", mem_val, i_host.rd_data)
      `CHK("rd_oe", 1'b1, oe_cnt > oe_c)
    end
    c0 = req_cnt;
    i_host.access(1'b0, 1'b1, HPC_SEL_DATA, 1'b0, 8'hA5, 1'b0);
    `CHK("no_cs_req", c0, req_cnt)
    mem_req_ready = 0;
    repeat (HPC_FIFO_DEPTH) i_host.access(1'b0, 1'b0, HPC_SEL_DATA, 1'b0, 8'h5A, 1'b0);
    `CHK("full_ready", 1'b0, host_port_ready)
    mem_req_ready = 1;
    repeat (16) @(negedge clk);
    `CHK("drained", c0 + HPC_FIFO_DEPTH, req_cnt)
    do_reset(1'b0);
    `CHK("disabled", 1'b0, port_enabled)
    host_port_module_enable = 1;
    repeat (4) @(negedge clk);
    `CHK("stay_disabled", 1'b0, port_enabled)
    `CHK("pullup_off", 1'b0, host_pullup_enable)
    c0 = req_cnt;
    i_host.access(1'b0, 1'b0, HPC_SEL_DATA, 1'b0, 8'h3C, 1'b0);
    `CHK("dis_req", c0, req_cnt)
    timer_on_interrupt_pin = 1;
    repeat (4) begin
      timer_one_output = 1'($urandom);
      @(negedge clk);
      `CHK("timer_pin", timer_one_output, host_interrupt_out)
    end
    host_port_module_enable = 0;
    repeat (4) @(negedge clk);
    `CHK("pullup_on", 1'b1, host_pullup_enable)
    finish_test();
  end
endmodule
